// ===== logic/rtcsp_pkg.sv
package rtcsp_pkg;
    localparam logic [6:0] RTCSP_ADDR_TIME_FIRST = 7'h00;
    localparam logic [6:0] RTCSP_ADDR_READ_LAST  = 7'h13;
    localparam logic [6:0] RTCSP_ADDR_TEMP_CTRL  = 7'h13;
    localparam logic [6:0] RTCSP_ADDR_SRAM_PTR   = 7'h18;
    localparam logic [6:0] RTCSP_ADDR_SRAM_WIN   = 7'h19;
    localparam logic [6:0] RTCSP_ADDR_WRITE_LAST = 7'h13;
    localparam int         RTCSP_CONV_DIS_BIT    = 0;
    localparam logic [7:0] RTCSP_TEMP_CTRL_RST   = 8'h00;
    localparam int         RTCSP_TIME_BYTES      = 7;
    localparam int         RTCSP_CLK_DIV         = 4;
    // Host command register map.
    localparam logic [1:0] RTCSP_H_ADDR          = 2'h0;
    localparam logic [1:0] RTCSP_H_DATA          = 2'h1;
    localparam logic [1:0] RTCSP_H_CTRL          = 2'h2;
    localparam logic [1:0] RTCSP_H_STAT          = 2'h3;
endpackage

// ===== logic/rtcsp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface rtcsp_if;
    logic cs_b;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport dev  (input cs_b, sclk, mosi, output miso, miso_oe);
    modport host (output cs_b, sclk, mosi, input miso, miso_oe);
endinterface
`default_nettype wire

// ===== logic/rtcsp_sync3.sv
`timescale 1ns/100ps
`default_nettype none
module rtcsp_sync3
(
    // Clock and reset.
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    // Asynchronous level and its filtered copy.
    input  wire logic async_in,
    input  wire logic init_in,
    output var  logic level_out
);
    logic s1;
    logic s2;
    logic s3;

    // The output register only lets a change through once the second and third stages agree.
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            level_out <= 1'b1;
        end
        else
        begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level_out <= s3;
        end
    end
    wire unused_init = init_in;
endmodule
`default_nettype wire

// ===== logic/rtcsp_dev.sv
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module rtcsp_dev
(
    // Clock and reset.
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    // Link.
    rtcsp_if.dev            spi,
    // Timekeeping core side.
    input  wire logic [55:0] live_time_in,
    input  wire logic       on_battery_in,
    input  wire logic       conv_tick_in,
    input  wire logic       alarm_match_in,
    output var  logic [55:0] time_copy_out,
    output var  logic       conv_start_out,
    output var  logic       battery_conv_disable_out,
    output var  logic       irq_square_b_out
);
    import rtcsp_pkg::*;

    logic       cs_b_s;
    logic       sclk_s;
    logic       mosi_s;
    logic       sclk_d;
    logic       cs_d;
    logic       cpol;
    logic [2:0] bit_cnt;
    logic [7:0] shin;
    logic [7:0] shout;
    logic       have_addr;
    logic       wr_dir;
    logic [6:0] ptr;
    logic       read_ok;
    logic [7:0] temp_ctrl;
    logic [7:0] sram_ptr;
    logic [7:0] sram [0:255];
    logic [7:0] rd_byte;
    logic [7:0] next_byte;
    logic       strobe;
    logic       shift;

    rtcsp_sync3 u_cs   (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .async_in(spi.cs_b),
                        .init_in(1'b1), .level_out(cs_b_s));
    rtcsp_sync3 u_sclk (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .async_in(spi.sclk),
                        .init_in(1'b1), .level_out(sclk_s));
    rtcsp_sync3 u_mosi (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .async_in(spi.mosi),
                        .init_in(1'b1), .level_out(mosi_s));

    // Strobe is the edge back to the idle level of the clock, shift the edge away from it.
    always_comb
    begin
        strobe = !cs_b_s && (sclk_s != sclk_d) && (sclk_s == cpol);
        shift  = !cs_b_s && (sclk_s != sclk_d) && (sclk_s != cpol);
        next_byte = {shin[6:0], mosi_s};
    end

    always_comb
    begin
        read_ok = (ptr < RTCSP_TIME_BYTES[6:0]) || ptr == RTCSP_ADDR_TEMP_CTRL ||
                  ptr == RTCSP_ADDR_SRAM_PTR || ptr == RTCSP_ADDR_SRAM_WIN;
        rd_byte = 8'h00;
        if (ptr < RTCSP_TIME_BYTES[6:0])
            rd_byte = time_copy_out[8'(55 - 8 * ptr) -: 8];
        else if (ptr == RTCSP_ADDR_TEMP_CTRL)
            rd_byte = temp_ctrl;
        else if (ptr == RTCSP_ADDR_SRAM_PTR)
            rd_byte = sram_ptr;
        else if (ptr == RTCSP_ADDR_SRAM_WIN)
            rd_byte = sram[sram_ptr];
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sclk_d <= 1'b1;
            cs_d   <= 1'b1;
            cpol   <= 1'b1;
        end
        else
        begin
            sclk_d <= sclk_s;
            cs_d   <= cs_b_s;
            if (cs_d && !cs_b_s)
                cpol <= sclk_s;
        end
    end

    // Frame and byte engine; a deselect drops everything partial.
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bit_cnt   <= 3'h0;
            shin      <= 8'h00;
            have_addr <= 1'b0;
            wr_dir    <= 1'b0;
            ptr       <= 7'h00;
        end
        else if (cs_b_s)
        begin
            bit_cnt   <= 3'h0;
            have_addr <= 1'b0;
        end
        else if (strobe)
        begin
            bit_cnt <= bit_cnt + 3'h1;
            shin    <= next_byte;
            if (bit_cnt == 3'h7)
            begin
                if (!have_addr)
                begin
                    have_addr <= 1'b1;
                    wr_dir    <= next_byte[7];
                    ptr       <= next_byte[6:0];
                end
                else if (ptr != RTCSP_ADDR_SRAM_WIN)
                begin
                    if (wr_dir && ptr == RTCSP_ADDR_WRITE_LAST)
                        ptr <= RTCSP_ADDR_TIME_FIRST;
                    else if (!wr_dir && ptr == RTCSP_ADDR_READ_LAST)
                        ptr <= RTCSP_ADDR_TIME_FIRST;
                    else
                        ptr <= ptr + 7'h1;
                end
            end
        end
    end

    // Written registers; the SRAM pointer and array carry no reset value.
    always_ff @(posedge ref_clk_in)
    begin
        if (!cs_b_s && strobe && bit_cnt == 3'h7 && have_addr)
        begin
            if (ptr == RTCSP_ADDR_SRAM_WIN)
            begin
                if (wr_dir)
                    sram[sram_ptr] <= next_byte;
                sram_ptr <= sram_ptr + 8'h01;
            end
            else if (wr_dir && ptr == RTCSP_ADDR_SRAM_PTR)
                sram_ptr <= next_byte;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            temp_ctrl <= RTCSP_TEMP_CTRL_RST;
        else if (!cs_b_s && strobe && bit_cnt == 3'h7 && have_addr && wr_dir &&
                 ptr == RTCSP_ADDR_TEMP_CTRL)
            temp_ctrl <= {7'h00, next_byte[RTCSP_CONV_DIS_BIT]};
    end

    // Time copy refresh at select and when a read wraps.
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            time_copy_out <= 56'h0;
        else if ((cs_d && !cs_b_s) ||
                 (strobe && bit_cnt == 3'h7 && have_addr && !wr_dir && ptr == RTCSP_ADDR_READ_LAST))
            time_copy_out <= live_time_in;
    end

    // Output shifter: each byte is fetched whole at its first shift edge, so the pin
    // only leaves high impedance with all eight bits of a valid location behind it.
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            shout       <= 8'h00;
            spi.miso    <= 1'b0;
            spi.miso_oe <= 1'b0;
        end
        else if (cs_b_s || wr_dir || !have_addr)
        begin
            spi.miso_oe <= 1'b0;
        end
        else if (shift && bit_cnt == 3'h0)
        begin
            spi.miso    <= rd_byte[7];
            spi.miso_oe <= read_ok;
            shout       <= {rd_byte[6:0], 1'b0};
        end
        else if (shift)
        begin
            spi.miso <= shout[7];
            shout    <= {shout[6:0], 1'b0};
        end
    end

    // Conversions and alarm pin run on live state only.
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            conv_start_out           <= 1'b0;
            battery_conv_disable_out <= 1'b0;
            irq_square_b_out         <= 1'b1;
        end
        else
        begin
            battery_conv_disable_out <= temp_ctrl[RTCSP_CONV_DIS_BIT];
            conv_start_out <= conv_tick_in && !(on_battery_in && temp_ctrl[RTCSP_CONV_DIS_BIT]);
            irq_square_b_out <= !alarm_match_in;
        end
    end
endmodule
`default_nettype wire

// ===== logic/rtcsp_host.sv
`timescale 1ns/100ps
`default_nettype none
module rtcsp_host
(
    // Clock and reset.
    input  wire logic       ref_clk_in,
    input  wire logic       rst_b_in,
    // Command port.
    input  wire logic [1:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output var  logic [7:0] rdata_out,
    // Link.
    rtcsp_if.host           spi
);
    import rtcsp_pkg::*;

    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] rx_last;
    logic [3:0] bits;
    logic [3:0] div;
    logic       busy;
    logic       done;
    logic       miso_s;

    rtcsp_sync3 u_miso (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .async_in(spi.miso),
                        .init_in(1'b1), .level_out(miso_s));

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            case (addr_in)
                RTCSP_H_DATA: rdata_out <= rx_last;
                RTCSP_H_STAT: rdata_out <= {6'h00, done, busy};
                default:      rdata_out <= 8'h00;
            endcase
    end

    // Mode 3 master: idle high, device samples rising, host samples rising late.
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            spi.cs_b <= 1'b1;
            spi.sclk <= 1'b1;
            spi.mosi <= 1'b0;
            tx <= 8'h00;
            rx <= 8'h00;
            rx_last <= 8'h00;
            bits <= 4'h0;
            div <= 4'h0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (wr_in && addr_in == RTCSP_H_CTRL)
        begin
            spi.cs_b <= !wdata_in[0];
            done <= 1'b0;
        end
        else if (wr_in && (addr_in == RTCSP_H_ADDR || addr_in == RTCSP_H_DATA) && !busy)
        begin
            tx <= wdata_in;
            busy <= 1'b1;
            done <= 1'b0;
            bits <= 4'h0;
            div <= 4'h0;
        end
        else if (busy)
        begin
            div <= div + 4'h1;
            if (div == 4'(RTCSP_CLK_DIV - 1) && bits != 4'h8)
            begin
                spi.sclk <= 1'b0;
                spi.mosi <= tx[7];
                tx <= {tx[6:0], 1'b0};
            end
            else if (div == 4'(2 * RTCSP_CLK_DIV - 1))
            begin
                spi.sclk <= 1'b1;
                div <= 4'h0;
                bits <= bits + 4'h1;
                // The returned bit crosses two synchronisers and lags more than half a period,
                // so each bit is taken one period late and a ninth idle period collects the last.
                if (bits != 4'h0)
                    rx <= {rx[6:0], miso_s};
                if (bits == 4'h8)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    rx_last <= {rx[6:0], miso_s};
                end
            end
        end
    end
    wire unused_oe = spi.miso_oe;
endmodule
`default_nettype wire

// ===== testbench/rtcsp_props.sv
`timescale 1ns/100ps
`default_nettype none
module rtcsp_props
(
    // Clock and reset.
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    // Link signals.
    input  wire logic cs_b,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    logic       sclk_q;
    logic [9:0] bits;
    logic       wr_dir;

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
        if (!rst_b_in)
            sclk_q <= 1'b1;
        else
            sclk_q <= sclk;

    // Counts host strobe edges in the frame; the first one carries the direction.
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
        if (!rst_b_in)
            bits <= 10'h000;
        else if (cs_b)
            bits <= 10'h000;
        else if (sclk && !sclk_q)
            bits <= bits + 10'h001;

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
        if (!rst_b_in)
            wr_dir <= 1'b0;
        else if (cs_b)
            wr_dir <= 1'b0;
        else if (sclk && !sclk_q && bits == 10'h000)
            wr_dir <= mosi;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    sequence s_desel_long;
        cs_b [*8];
    endsequence
    sequence s_strobe;
        !cs_b && $rose(sclk);
    endsequence

    AST_IDLE_CLK_HIGH: assert property (cs_b |-> sclk)
        else $error("serial clock low while deselected");
    AST_SELECT_MODE: assert property ($fell(cs_b) |-> sclk)
        else $error("select fell with clock low");
    AST_OE_OFF_IDLE: assert property (s_desel_long |-> !miso_oe)
        else $error("output driven while deselected");
    AST_MOSI_HOLD: assert property (s_strobe |-> $stable(mosi) ##1 $stable(mosi))
        else $error("input data moved at strobe edge");
    AST_NO_OE_EARLY: assert property (!cs_b && bits < 10'h008 |-> !miso_oe)
        else $error("output driven during address byte");
    AST_NO_OE_WRITE: assert property (!cs_b && wr_dir |-> !miso_oe)
        else $error("output driven in write frame");
    AST_WHOLE_BYTES: assert property ($rose(cs_b) |-> bits[2:0] == 3'h0)
        else $error("frame ended mid byte");
    AST_BIT_SPAN: assert property (s_strobe |-> sclk [*2])
        else $error("serial clock high phase too short");
endmodule
`default_nettype wire

// ===== testbench/test_spi_rtc_register_sram_access.sv
`timescale 1ns/100ps
`default_nettype none
module test_spi_rtc_register_sram_access;
    import rtcsp_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [1:0]  addr = 2'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic [55:0] live_time = 56'h0;
    logic        on_batt = 1'b0;
    logic        tick = 1'b0;
    logic        alarm = 1'b0;
    logic [55:0] time_copy;
    logic        conv_start;
    logic        conv_dis;
    logic        irq_b;
    logic [7:0]  lfsr = 8'h55;
    logic [7:0]  mem [256];
    logic [7:0]  tx [$];
    logic [7:0]  rx [$];
    logic [55:0] nt;
    logic        oe_seen = 1'b0;
    int          conv_cnt = 0;
    int          fail_count = 0;
    int          samples_checked = 0;
    rtcsp_if link ();
    always #10 ref_clk_in = ~ref_clk_in;
    rtcsp_host i_rtcsp_host (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .spi(link.host));
    rtcsp_dev i_rtcsp_dev (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .spi(link.dev), .live_time_in(live_time),
        .on_battery_in(on_batt), .conv_tick_in(tick), .alarm_match_in(alarm), .time_copy_out(time_copy),
        .conv_start_out(conv_start), .battery_conv_disable_out(conv_dis), .irq_square_b_out(irq_b));
    rtcsp_props i_rtcsp_props (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .cs_b(link.cs_b), .sclk(link.sclk),
        .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));
    always @(posedge ref_clk_in)
    begin
        if (conv_start === 1'b1)
            conv_cnt++;
        if (link.miso_oe === 1'b1)
            oe_seen = 1'b1;
    end
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Bytes are refused while busy, so each shift polls the status under a bound.
    task automatic shift(input logic [1:0] a, input logic [7:0] b, output logic [7:0] r);
        logic [7:0] s;
        int         k;
        wr_reg(a, b);
        s = 8'h01;
        k = 0;
        while (s[0] !== 1'b0 && k < 300)
        begin
            rd_reg(RTCSP_H_STAT, s);
            k++;
        end
        chk(s[0], 1'b0);
        rd_reg(RTCSP_H_DATA, r);
    endtask
    task automatic frame(input logic [7:0] a, input int n, input logic [55:0] t);
        logic [7:0] r;
        oe_seen = 1'b0;
        rx = {};
        wr_reg(RTCSP_H_CTRL, 8'h01);
        repeat (8) @(posedge ref_clk_in);
        live_time <= t;
        shift(RTCSP_H_ADDR, a, r);
        for (int i = 0; i < n; i++)
        begin
            shift(RTCSP_H_DATA, (tx.size() > i) ? tx[i] : 8'h00, r);
            rx.push_back(r);
        end
        wr_reg(RTCSP_H_CTRL, 8'h00);
        repeat (12) @(posedge ref_clk_in);
    endtask
    task automatic tick_pulse();
        @(posedge ref_clk_in);
        tick <= 1'b1;
        @(posedge ref_clk_in);
        tick <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #1000000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        repeat (4) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        chk(link.cs_b, 1'b1);
        chk(conv_dis, RTCSP_TEMP_CTRL_RST[RTCSP_CONV_DIS_BIT]);
        chk(irq_b, 1'b1);
        tx = '{8'h01};
        frame(8'h93, 1, live_time);
        chk(oe_seen, 1'b0);
        chk(conv_dis, 1'b1);
        on_batt <= 1'b1;
        tick_pulse();
        chk(conv_cnt, 0);
        on_batt <= 1'b0;
        tick_pulse();
        chk(conv_cnt, 1);
        // The pointer starts near the top so the burst crosses FFh to 00h.
        tx = '{8'hFE};
        frame(8'h98, 1, live_time);
        tx = '{rnd(), rnd(), rnd()};
        for (int i = 0; i < 3; i++)
            mem[8'(8'hFE + i)] = tx[i];
        frame(8'h99, 3, live_time);
        tx = '{8'hFE};
        frame(8'h98, 1, live_time);
        tx = {};
        frame(8'h19, 3, live_time);
        for (int i = 0; i < 3; i++)
            chk(rx[i], mem[8'(8'hFE + i)]);
        frame(8'h18, 1, live_time);
        chk(rx[0], 8'h01);
        for (int i = 0; i < 7; i++)
            nt = {nt[47:0], rnd()};
        live_time <= nt;
        frame(8'h00, 7, nt);
        for (int i = 0; i < 7; i++)
            chk(rx[i], nt[55 - 8 * i -: 8]);
        chk(oe_seen, 1'b1);
        chk(time_copy, nt);
        // The new time arrives after select, so only the wrap can load it.
        for (int i = 0; i < 7; i++)
            nt = {nt[47:0], rnd()};
        frame(8'h13, 2, nt);
        chk(rx[0], 8'h01);
        chk(rx[1], nt[55:48]);
        frame(8'h15, 1, nt);
        chk(oe_seen, 1'b0);
        @(posedge ref_clk_in);
        alarm <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1;
        chk(irq_b, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
